// [design/rst_cause_defines.svh]
// constants for the reset source and cause logic
// assumes a 25 MHz system clock and 32-bit AXI4-Lite access
`ifndef RST_CAUSE_DEFINES_SVH
`define RST_CAUSE_DEFINES_SVH

// byte addresses of the registers
`define STATUS_ADDR 12'hFF0
`define DEBUG_CTL_ADDR 12'hFF4

// status field positions
`define POR_BIT 7
`define STOP_BIT 6
`define WDT_BIT 5
`define EXT_BIT 4

// status value after power-on reset
`define STATUS_RESET 8'h80
// mask kept by a status read (upper four bits clear)
`define STATUS_KEEP_MASK 8'h0F
// debug control bit that requests a reset
`define DEBUG_RESET_BIT 1

// timing
`define CLK_PERIOD_NS 40
`define PIN_MIN_CYCLES 4
`define GLITCH_MIN_NS 200
`define GLITCH_CYCLES \
  ((`GLITCH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_CYCLES 16

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [design/rst_cause_pkg.sv]
// types for the reset source and cause logic
// assumes rst_cause_defines.svh holds the numbers
package rst_cause_pkg;

  // reset cause flags as seen in the status register
  typedef struct packed {
    logic por;
    logic stop;
    logic wdt;
    logic external_pin_flag;
    logic [3:0] rsvd;
  } status_type;

  // reset sequencer states
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RESET = 1'b1
  } seq_type;

  // reset pin synchroniser (the debugger pin is used unsynchronised)
  typedef struct packed {
    logic meta;
    logic sync;
  } sync_type;

  // whole module state
  typedef struct packed {
    status_type status;
    seq_type seq;
    logic [7:0] hold_cnt;
    sync_type pin;
    logic [7:0] low_cnt;
    logic [7:0] wdt_ctl;
    logic wdt_ctl_wr;
    logic [7:0] debug_ctl;
    logic wdt_irq;
    logic stop_recover;
    logic aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;

endpackage

// [design/reset_cause_logic.sv]
// reset source handling and reset cause status register
// assumes one 25 MHz clock, synchronous inputs, AXI4-Lite master
//
// Function
// [R1] watchdog time-out resets when select is 1
// [R2] select 0: watchdog time-out raises interrupt
// [R3] watchdog reset sets the watchdog flag
// [R4] pin low four cycles starts system reset
// [R5] stop mode: filtered low pin resets
// [R6] read-only status register at FF0
// [R7] any status read clears upper four bits
// [R8] writes at FF0 go to watchdog control
// [R9] flags in bits 7..4, bits 3..0 zero
// [R10] power-on sets only the power-on flag
// [R11] pin reset sets only the pin flag
// [R12] watchdog reset sets only watchdog flag
// [R13] debugger reset recorded like power-on
// [R14] stop mode debug pin low like power-on
// [R15] gpio stop recovery sets only stop flag
// [R16] watchdog stop recovery sets stop and watchdog
// [R17] power-on flag cleared by watchdog, recovery, read
// [R18] reset pin comes up with pull-up, open-drain
// [R19] clear on read after data captured
// [R20] reset pin synchronised before counting
`include "rst_cause_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module reset_cause_logic
  import rst_cause_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int HOLD_CYCLES = `RESET_HOLD_CYCLES,
  parameter int GLITCH_CYCLES = `GLITCH_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  // axi4-lite write response
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  // axi4-lite read data
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // shared reset pin, open drain
  input wire logic I_RESET_PIN,
  output logic O_RESET_PIN_OUT,
  output logic O_RESET_PIN_OE,
  output logic O_RESET_PIN_PULLUP,
  output logic O_RESET_PIN_FUNC,
  // reset sources
  input wire logic I_STOP_MODE,
  input wire logic I_WATCHDOG_RESET_SELECT,
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_GPIO_RECOVER,
  input wire logic I_DEBUG_PIN,
  // results
  output logic O_SYS_RESET,
  output logic O_WDT_IRQ,
  output logic O_STOP_RECOVER,
  output logic [7:0] O_WDT_CTL,
  output logic O_WDT_CTL_WR
);

  state_type st; // registered state
  state_type next_st; // next state

  // combinational helpers
  logic [ADDR_W-1:0] wr_addr; // write address in use
  logic [ADDR_W-1:0] rd_addr; // read address in use
  logic aw_take; // write address taken now
  logic w_take; // write data taken now
  logic ar_take; // read address taken now
  logic do_write; // both write halves present
  logic [7:0] pin_limit; // low cycles needed on the pin
  logic pin_event; // filtered pin reset
  logic debug_req; // debugger reset request
  logic dbgpin_event; // debug pin low in stop mode
  logic wdt_reset; // watchdog causes a reset
  logic wdt_irq_ev; // watchdog causes an interrupt
  logic gpio_event; // gpio stop recovery
  logic any_reset; // a reset must start

  // handshake outputs, ready while nothing is pending
  assign aw_take = I_AWVALID && !st.aw_got && !st.bvalid;
  assign w_take = I_WVALID && !st.w_got && !st.bvalid;
  assign ar_take = I_ARVALID && !st.rvalid;
  assign O_AWREADY = !st.aw_got && !st.bvalid;
  assign O_WREADY = !st.w_got && !st.bvalid;
  assign O_ARREADY = !st.rvalid;

  // registered outputs
  assign O_BVALID = st.bvalid;
  assign O_BRESP = st.bresp;
  assign O_RVALID = st.rvalid;
  assign O_RDATA = st.rdata;
  assign O_RRESP = st.rresp;
  assign O_SYS_RESET = (st.seq == SEQ_RESET);
  assign O_WDT_IRQ = st.wdt_irq;
  assign O_STOP_RECOVER = st.stop_recover;
  assign O_WDT_CTL = st.wdt_ctl;
  assign O_WDT_CTL_WR = st.wdt_ctl_wr;
  // pin keeps its reset role with pull-up and open drain
  assign O_RESET_PIN_FUNC = 1'b1; // R18
  assign O_RESET_PIN_PULLUP = 1'b1; // R18
  // drive the pin low while the system reset is held
  assign O_RESET_PIN_OUT = 1'b0;
  assign O_RESET_PIN_OE = (st.seq == SEQ_RESET); // R18

  // source detection
  always_comb begin
    // pin needs four cycles, longer in stop mode
    pin_limit = 8'(`PIN_MIN_CYCLES); // R4
    if (I_STOP_MODE && GLITCH_CYCLES > `PIN_MIN_CYCLES) begin
      pin_limit = 8'(GLITCH_CYCLES); // R5
    end
    // low_cnt holds the earlier low cycles, the current one adds one
    pin_event = !st.pin.sync && (st.low_cnt >= pin_limit - 8'h01); // R4 R5
    debug_req = st.debug_ctl[`DEBUG_RESET_BIT]; // R13
    dbgpin_event = I_STOP_MODE && !I_DEBUG_PIN; // R14
    wdt_reset = I_WDT_TIMEOUT && I_WATCHDOG_RESET_SELECT; // R1
    wdt_irq_ev = I_WDT_TIMEOUT && !I_WATCHDOG_RESET_SELECT; // R2
    gpio_event = I_STOP_MODE && I_GPIO_RECOVER; // R15
    any_reset = pin_event || debug_req || dbgpin_event || wdt_reset;
  end

  // next state
  always_comb begin
    next_st = st;
    wr_addr = st.aw_got ? st.aw_addr : I_AWADDR;
    rd_addr = I_ARADDR;
    do_write = 1'b0;
    next_st.wdt_ctl_wr = 1'b0;
    next_st.wdt_irq = 1'b0;
    next_st.stop_recover = 1'b0;

    // reset pin synchroniser, second stage only is used
    next_st.pin.meta = I_RESET_PIN; // R20
    next_st.pin.sync = st.pin.meta; // R20
    // count synchronised low cycles, ignore our own drive
    if (st.pin.sync || st.seq == SEQ_RESET) begin
      next_st.low_cnt = 8'h00;
    end else if (st.low_cnt != 8'hFF) begin
      next_st.low_cnt = st.low_cnt + 8'h01; // R20
    end

    // write channel capture, either order
    if (aw_take) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = I_AWADDR[11:0];
    end
    if (w_take) begin
      next_st.w_got = 1'b1;
      next_st.w_data = I_WDATA;
      next_st.w_strb = I_WSTRB;
    end
    do_write = (st.aw_got || aw_take) && (st.w_got || w_take);

    // write decode
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RESP_OKAY;
      if (wr_addr == `STATUS_ADDR) begin
        // status address takes watchdog control on write
        if ((w_take ? I_WSTRB[0] : st.w_strb[0])) begin
          next_st.wdt_ctl = w_take ? I_WDATA[7:0] : st.w_data[7:0]; // R8
          next_st.wdt_ctl_wr = 1'b1; // R8
        end
      end else if (wr_addr == `DEBUG_CTL_ADDR) begin
        // debugger control byte
        if ((w_take ? I_WSTRB[0] : st.w_strb[0])) begin
          next_st.debug_ctl = w_take ? I_WDATA[7:0] : st.w_data[7:0];
        end
      end else begin
        // unmapped address
        next_st.bresp = `RESP_SLVERR;
      end
    end else if (st.bvalid && I_BREADY) begin
      next_st.bvalid = 1'b0;
    end

    // read decode, data captured before the clear
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      if (rd_addr == `STATUS_ADDR) begin
        next_st.rdata = {24'h00_0000, st.status}; // R6 R9 R19
        next_st.rdata[3:0] = 4'h0; // R9
        // upper four flags cleared by the read
        next_st.status = st.status & `STATUS_KEEP_MASK; // R7 R17
      end else if (rd_addr == `DEBUG_CTL_ADDR) begin
        next_st.rdata = {24'h00_0000, st.debug_ctl};
      end else begin
        // unmapped address reads zero
        next_st.rresp = `RESP_SLVERR;
      end
    end else if (st.rvalid && I_RREADY) begin
      next_st.rvalid = 1'b0;
    end

    // watchdog interrupt and stop recovery, set wins over read clear
    if (wdt_irq_ev) begin
      next_st.wdt_irq = 1'b1; // R2
      next_st.status.wdt = 1'b1;
      next_st.status.por = 1'b0; // R17
      if (I_STOP_MODE) begin
        next_st.status.stop = 1'b1; // R16
        next_st.stop_recover = 1'b1; // R16
      end
    end else if (gpio_event && !any_reset && st.seq == SEQ_IDLE) begin
      next_st.status = '0;
      next_st.status.stop = 1'b1; // R15 R17
      next_st.stop_recover = 1'b1;
    end

    // reset sequencer
    case (st.seq)
      SEQ_IDLE: begin
        if (any_reset) begin
          next_st.seq = SEQ_RESET;
          next_st.hold_cnt = 8'(HOLD_CYCLES - 1);
          next_st.debug_ctl[`DEBUG_RESET_BIT] = 1'b0;
          next_st.status = '0;
          if (pin_event) begin
            next_st.status.external_pin_flag = 1'b1; // R11
          end else if (debug_req || dbgpin_event) begin
            next_st.status.por = 1'b1; // R13 R14
          end else if (I_STOP_MODE) begin
            // watchdog out of stop mode
            next_st.status.stop = 1'b1; // R16 R17
            next_st.status.wdt = 1'b1; // R16
            next_st.stop_recover = 1'b1;
          end else begin
            next_st.status.wdt = 1'b1; // R3 R12
          end
        end
      end
      SEQ_RESET: begin
        // hold the system reset for a fixed time
        if (st.hold_cnt == 8'h00) begin
          next_st.seq = SEQ_IDLE;
        end else begin
          next_st.hold_cnt = st.hold_cnt - 8'h01;
        end
      end
      default: begin
        next_st.seq = SEQ_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= '{status: `STATUS_RESET, seq: SEQ_IDLE,
              pin: '{meta: 1'b1, sync: 1'b1}, default: '0}; // R10
    end else begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

// [verif/reset_cause_monitor.sv]
// port checker for the reset cause block
// assumes a bind from the bench top and one clock domain
`timescale 1ns/100ps
`default_nettype none
module reset_cause_monitor #(
  parameter int HOLD_CYCLES = 16
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [11:0] I_ARADDR,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_WATCHDOG_RESET_SELECT,
  input wire logic I_GPIO_RECOVER,
  input wire logic I_STOP_MODE,
  input wire logic O_SYS_RESET,
  input wire logic O_WDT_IRQ,
  input wire logic O_STOP_RECOVER,
  input wire logic O_WDT_CTL_WR,
  input wire logic O_BVALID,
  input wire logic O_RESET_PIN_PULLUP,
  input wire logic O_RESET_PIN_FUNC,
  input wire logic O_RESET_PIN_OUT,
  input wire logic O_RESET_PIN_OE
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  logic [7:0] hi; // cycles the system reset has stood
  logic stat_rd; // the read in flight targets the status word
  // helper counter and flag, cleared with the block
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hi <= 8'h00;
      stat_rd <= 1'b0;
    end else begin
      hi <= O_SYS_RESET ? hi + 8'h01 : 8'h00;
      if (I_ARVALID && O_ARREADY) stat_rd <= (I_ARADDR == 12'hFF0);
    end
  end
  a_wdt_reset: assert property (
    I_WDT_TIMEOUT && I_WATCHDOG_RESET_SELECT && !O_SYS_RESET |=> O_SYS_RESET)
    else $error("no reset after watchdog");
  a_wdt_irq: assert property (
    I_WDT_TIMEOUT && !I_WATCHDOG_RESET_SELECT && !O_SYS_RESET
    |=> O_WDT_IRQ && !O_SYS_RESET) else $error("bad watchdog interrupt");
  a_hold_len: assert property (
    $fell(O_SYS_RESET) |-> hi == 8'(HOLD_CYCLES)) else $error("bad hold");
  a_read_answer: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID) else $error("no read answer");
  a_status_rsvd: assert property (
    O_RVALID && stat_rd |-> O_RDATA[31:8] == 24'h0 && O_RDATA[3:0] == 4'h0)
    else $error("status low bits set");
  a_ctl_write: assert property (
    O_WDT_CTL_WR |-> O_BVALID) else $error("control write unanswered");
  a_stop_recover: assert property (
    I_GPIO_RECOVER && I_STOP_MODE && !O_SYS_RESET |=> O_STOP_RECOVER)
    else $error("no stop recovery");
  a_pin_pullup: assert property (
    O_RESET_PIN_PULLUP) else $error("reset pin pull-up off");
  a_pin_drive: assert property (
    O_RESET_PIN_FUNC && !O_RESET_PIN_OUT && (O_RESET_PIN_OE == O_SYS_RESET))
    else $error("reset pin role or drive wrong");
endmodule
`default_nettype wire

// [verif/reset_far_side.sv]
// far side model: reset pin driver, watchdog, debug pin, gpio
// assumes the bench forms the open-drain pin level with a pull-up
`timescale 1ns/100ps
`default_nettype none
module reset_far_side (
  input wire logic i_clk,
  output logic o_pin_low,
  output logic o_wdt_pulse,
  output logic o_debug_pin,
  output logic o_gpio_pulse
);
  // all lines idle at time zero
  initial begin
    o_pin_low = 1'b0;
    o_wdt_pulse = 1'b0;
    o_debug_pin = 1'b1;
    o_gpio_pulse = 1'b0;
  end
  // pull the reset pin low n cycles, then the pull-up wins
  task automatic hold_low(input int n);
    o_pin_low <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_pin_low <= 1'b0;
  endtask
  // one-cycle watchdog time-out or gpio transition
  task automatic pulse(input logic gpio);
    if (gpio) o_gpio_pulse <= 1'b1;
    else o_wdt_pulse <= 1'b1;
    @(posedge i_clk);
    o_gpio_pulse <= 1'b0;
    o_wdt_pulse <= 1'b0;
  endtask
  // drive the debug pin low for a few cycles
  task automatic dbg_low();
    o_debug_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_debug_pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [verif/reset_cause_logic_tb.sv]
// self-checking bench for the reset cause block
// assumes the monitor and far side model are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got %0h exp %0h", $time, a, e); end end
module reset_cause_logic_tb;
  localparam int HOLD = 4;
  logic clk, rst_n, awv, wv, arv, brdy, rrdy, awr, wr_r, arr, bv, rv;
  logic stop, sel, dbg, gpio, wdt, far_low, oe, sysr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [7:0] wctl;
  logic [1:0] br, rr;
  int mismatches, n_tests, cyc;
  wire pin = !(far_low || oe); // open drain with pull-up
  reset_cause_logic #(.HOLD_CYCLES(HOLD)) u_dut (.I_CLK(clk), .I_RST_N(rst_n),
    .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd),
    .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr_r), .O_BRESP(br),
    .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv),
    .I_RREADY(rrdy), .I_RESET_PIN(pin), .O_RESET_PIN_OUT(),
    .O_RESET_PIN_OE(oe), .O_RESET_PIN_PULLUP(), .O_RESET_PIN_FUNC(),
    .I_STOP_MODE(stop), .I_WATCHDOG_RESET_SELECT(sel),
    .I_WDT_TIMEOUT(wdt), .I_GPIO_RECOVER(gpio), .I_DEBUG_PIN(dbg),
    .O_SYS_RESET(sysr), .O_WDT_IRQ(), .O_STOP_RECOVER(), .O_WDT_CTL(wctl),
    .O_WDT_CTL_WR());
  reset_far_side u_far (.i_clk(clk), .o_pin_low(far_low), .o_wdt_pulse(wdt),
    .o_debug_pin(dbg), .o_gpio_pulse(gpio));
  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      summarize();
    end
  end
  // bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    `CHK(br, er)
    brdy <= 1'b0;
    @(posedge clk);
  endtask
  // bus read with expected data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    `CHK(rdat, e)
    `CHK(rr, er)
    rrdy <= 1'b0;
    @(posedge clk);
  endtask
  // one reset or recovery source, then read and clear the cause
  task automatic step(input logic s, input logic w, input int k,
                      input int n, input logic [31:0] e);
    stop <= s;
    sel <= w;
    @(posedge clk);
    case (k)
      0: u_far.hold_low(n);
      1: u_far.pulse(1'b0);
      2: u_far.pulse(1'b1);
      3: u_far.dbg_low();
      default: wr(12'hFF4, 32'h2, 2'h0);
    endcase
    repeat (4 * HOLD) @(posedge clk);
    stop <= 1'b0;
    @(posedge clk);
    rd(12'hFF0, e, 2'h0);
  endtask
  // main sequence
  initial begin
    {rst_n, awv, wv, arv, brdy, rrdy, stop, awa, ara, wd} = '0;
    {mismatches, n_tests, cyc} = '0;
    sel = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(12'hFF0, 32'h80, 2'h0);
    rd(12'hFF0, 32'h00, 2'h0);
    wr(12'hFF0, 32'hA5, 2'h0);
    `CHK(wctl, 8'hA5)
    rd(12'hFF0, 32'h00, 2'h0);
    rd(12'h100, 32'h00, 2'h2);
    wr(12'h100, 32'h01, 2'h2);
    step(0, 1, 0, 8, 32'h10);
    step(0, 1, 0, 4, 32'h10);
    step(0, 1, 0, 3, 32'h00);
    step(0, 1, 1, 0, 32'h20);
    step(0, 0, 1, 0, 32'h20);
    step(0, 1, 4, 0, 32'h80);
    step(1, 1, 3, 0, 32'h80);
    step(1, 1, 2, 0, 32'h40);
    step(1, 1, 1, 0, 32'h60);
    step(1, 0, 1, 0, 32'h60);
    step(1, 1, 0, 4, 32'h00);
    step(1, 1, 0, 10, 32'h10);
    summarize();
  end
endmodule
bind reset_cause_logic reset_cause_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ARADDR(I_ARADDR),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
  .O_RVALID(O_RVALID), .I_WDT_TIMEOUT(I_WDT_TIMEOUT),
  .I_WATCHDOG_RESET_SELECT(I_WATCHDOG_RESET_SELECT),
  .I_GPIO_RECOVER(I_GPIO_RECOVER), .I_STOP_MODE(I_STOP_MODE),
  .O_SYS_RESET(O_SYS_RESET), .O_WDT_IRQ(O_WDT_IRQ),
  .O_STOP_RECOVER(O_STOP_RECOVER), .O_WDT_CTL_WR(O_WDT_CTL_WR),
  .O_BVALID(O_BVALID), .O_RESET_PIN_PULLUP(O_RESET_PIN_PULLUP),
  .O_RESET_PIN_FUNC(O_RESET_PIN_FUNC), .O_RESET_PIN_OUT(O_RESET_PIN_OUT),
  .O_RESET_PIN_OE(O_RESET_PIN_OE));
`default_nettype wire
